// ---- sim/adc_core_trim_registers_bench.sv ----
// Self-checking bench for the converter core trim register bank
`timescale 1ns/1ps
module adc_core_trim_registers_bench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp, fuse_ready;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] fuse_b_tim_in_a, fuse_a_tim_in_b, fuse_b_tim_in_b;
    logic [15:0] fuse_a_ofs_p0_in_a, fuse_a_ofs_p0_in_b, fuse_a_ofs_p90_in_a;
    logic interleaved_mode, fg_cal_en, clk_phase90, second_input_pair_sel;
    logic [7:0] core_a_timing_trim, core_b_timing_trim;
    logic [11:0] core_a_offset_trim;
    logic core_a_timing_valid, core_b_timing_valid, core_a_offset_valid;
    int miscompares, check_count;
    logic [31:0] exp_q[$];
    logic [31:0] lfsr;
    logic probe, rd_pend;
    logic [15:0] shadow [6];
    logic [15:0] fuse_tab [6];
    logic [9:0] idx_tab [6];

    // One slave on the bus, so its ready is the bus ready
    assign hready = hreadyout;

    actr_top dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fuse_ready(fuse_ready),
        .fuse_b_tim_in_a(fuse_b_tim_in_a), .fuse_a_tim_in_b(fuse_a_tim_in_b),
        .fuse_b_tim_in_b(fuse_b_tim_in_b), .fuse_a_ofs_p0_in_a(fuse_a_ofs_p0_in_a),
        .fuse_a_ofs_p0_in_b(fuse_a_ofs_p0_in_b), .fuse_a_ofs_p90_in_a(fuse_a_ofs_p90_in_a),
        .interleaved_mode(interleaved_mode), .fg_cal_en(fg_cal_en), .clk_phase90(clk_phase90),
        .second_input_pair_sel(second_input_pair_sel),
        .core_a_timing_trim(core_a_timing_trim), .core_a_timing_valid(core_a_timing_valid),
        .core_b_timing_trim(core_b_timing_trim), .core_b_timing_valid(core_b_timing_valid),
        .core_a_offset_trim(core_a_offset_trim), .core_a_offset_valid(core_a_offset_valid));

    // 25 MHz clock
    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'h0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Bounded wait for the bus ready; a hang ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hready !== 1'h1 && n < 50);
        if (hready !== 1'h1) begin
            miscompares++;
            results();
        end
    endtask

    // Single word transfer; a read notes its expected word first
    task automatic bus(input logic we, input logic [31:0] addr, input logic [31:0] wd,
                       input logic [31:0] ex);
        hsel <= 1'h1;
        haddr <= addr;
        hwrite <= we;
        htrans <= 2'h2;
        if (!we) begin
            exp_q.push_back(ex);
        end
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
    endtask

    function automatic logic [31:0] reg_addr(input int i);
        return {20'h0, idx_tab[i], 2'h0};
    endfunction

    // Expected core outputs for condition {interleaved, fg_cal, phase90, second pair}
    function automatic logic [31:0] route_exp(input logic [3:0] c);
        logic av, bv, ov;
        logic [7:0] at, bt;
        logic [11:0] ot;
        av = c[3] & c[2] & c[0];
        bv = c[3] & c[2];
        ov = c[2] & !(c[1] & c[0]);
        at = av ? shadow[1][7:0] : 8'h00;
        bt = !bv ? 8'h00 : (c[0] ? shadow[2][7:0] : shadow[0][7:0]);
        ot = !ov ? 12'h000 : (c[1] ? shadow[5][11:0] : (c[0] ? shadow[4][11:0] : shadow[3][11:0]));
        return {1'h0, av, at, bv, bt, ov, ot};
    endfunction

    // ------------------------------------------------------------
    // Monitor: takes the oldest note whenever a result appears
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (rd_pend && hready === 1'h1) begin
            check(hrdata, exp_q.size() ? exp_q.pop_front() : ~hrdata);
        end
        if (probe === 1'h1) begin
            check({hresp, core_a_timing_valid, core_a_timing_trim,
                core_b_timing_valid, core_b_timing_trim, core_a_offset_valid, core_a_offset_trim},
                exp_q.pop_front());
        end
        if (hready === 1'h1) begin
            rd_pend = (hsel === 1'h1) && (htrans[1] === 1'h1) && (hwrite === 1'h0);
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int i;
        logic [15:0] m;
        miscompares = 0;
        check_count = 0;
        rd_pend = 1'h0;
        probe = 1'h0;
        rst = 1'h1;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fuse_ready = 1'h0;
        {interleaved_mode, fg_cal_en, clk_phase90, second_input_pair_sel} = 4'h0;
        idx_tab = '{actr_pkg::IDX_B_TIM_IN_A, actr_pkg::IDX_A_TIM_IN_B, actr_pkg::IDX_B_TIM_IN_B,
            actr_pkg::IDX_A_OFS_P0_IN_A, actr_pkg::IDX_A_OFS_P0_IN_B, actr_pkg::IDX_A_OFS_P90_IN_A};
        lfsr = 32'hEBEE3D64;
        for (i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            fuse_tab[i] = (i < 3) ? {8'h00, lfsr[7:0]} : lfsr[31:16];
        end
        {fuse_b_tim_in_a, fuse_a_tim_in_b, fuse_b_tim_in_b} =
            {fuse_tab[0][7:0], fuse_tab[1][7:0], fuse_tab[2][7:0]};
        {fuse_a_ofs_p0_in_a, fuse_a_ofs_p0_in_b, fuse_a_ofs_p90_in_a} =
            {fuse_tab[3], fuse_tab[4], fuse_tab[5]};
        repeat (4) @(posedge mclk);
        rst <= 1'h0;
        // Bus must stall while the fuse copy has not happened
        repeat (3) @(posedge mclk);
        check({31'h0, hreadyout}, 32'h0);
        fuse_ready <= 1'h1;
        wait_ready();
        // Fuse defaults read back, every register
        for (i = 0; i < 6; i++) begin
            shadow[i] = fuse_tab[i];
            bus(1'h0, reg_addr(i), 32'h0, {16'h0, shadow[i]});
        end
        $display("test fuse defaults done");
        // Random full words written; each read back at once, upper bits dropped
        {interleaved_mode, fg_cal_en, clk_phase90, second_input_pair_sel} <= 4'hD;
        for (i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            m = (i < 3) ? 16'h00FF : 16'hFFFF;
            shadow[i] = lfsr[15:0] & m;
            bus(1'h1, reg_addr(i), lfsr, 32'h0);
            bus(1'h0, reg_addr(i), 32'h0, {16'h0, shadow[i]});
        end
        $display("test write readback done");
        // Unmapped places: holes, misaligned and high addresses
        bus(1'h1, 32'h0000_0C58, 32'hFFFF_FFFF, 32'h0);
        bus(1'h0, 32'h0000_0C58, 32'h0, 32'h0);
        bus(1'h1, 32'h0000_0D11, 32'hFFFF_FFFF, 32'h0);
        bus(1'h0, 32'h0001_0C54, 32'h0, 32'h0);
        bus(1'h1, 32'h0001_0C54, 32'hFFFF_FFFF, 32'h0);
        for (i = 0; i < 6; i++) begin
            bus(1'h0, reg_addr(i), 32'h0, {16'h0, shadow[i]});
        end
        $display("test unmapped done");
        // Every operating condition steers the right value
        for (i = 0; i < 16; i++) begin
            {interleaved_mode, fg_cal_en, clk_phase90, second_input_pair_sel} <= i[3:0];
            repeat (3) @(posedge mclk);
            exp_q.push_back(route_exp(i[3:0]));
            probe <= 1'h1;
            @(posedge mclk);
            probe <= 1'h0;
        end
        for (i = 0; i < 6; i++) begin
            bus(1'h0, reg_addr(i), 32'h0, {16'h0, shadow[i]});
        end
        $display("test routing done");
        // Second reset mid-run restores the fuse defaults
        rst <= 1'h1;
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        wait_ready();
        for (i = 0; i < 6; i++) begin
            shadow[i] = fuse_tab[i];
            bus(1'h0, reg_addr(i), 32'h0, {16'h0, shadow[i]});
        end
        $display("test second reset done");
        repeat (2) @(posedge mclk);
        results();
    end
endmodule

// ---- src/actr_fuse_loader.sv ----
// Sequencer that copies factory fuse values into the trim bank after reset
`timescale 1ns/1ps
module actr_fuse_loader (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Fuse storage handshake
    input wire logic fuse_ready,
    // Load strobe and bank ready
    output logic load_en,
    output logic bank_ready
);

    // ----------------------------------------------------------------
    // State machine
    // ----------------------------------------------------------------
    actr_pkg::actr_state_e state_q;
    actr_pkg::actr_state_e state_d;

    // Wait for fuses, load once, then hand the bank to software
    always_comb begin
        state_d = state_q;
        case (state_q)
            actr_pkg::ST_WAIT: begin
                if (fuse_ready) begin
                    state_d = actr_pkg::ST_LOAD;
                end
            end
            actr_pkg::ST_LOAD: begin
                state_d = actr_pkg::ST_RUN;
            end
            actr_pkg::ST_RUN: begin
                state_d = actr_pkg::ST_RUN;
            end
            default: begin
                state_d = actr_pkg::ST_WAIT;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= actr_pkg::ST_WAIT;
        end else begin
            state_q <= state_d;
        end
    end

    // Decoded outputs
    assign load_en = (state_q == actr_pkg::ST_LOAD);
    assign bank_ready = (state_q == actr_pkg::ST_RUN);

endmodule

// ---- src/actr_pkg.sv ----
// Constants and types shared by the converter core trim register bank
package actr_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [9:0] IDX_B_TIM_IN_A = 10'h315;
    localparam logic [9:0] IDX_A_TIM_IN_B = 10'h31A;
    localparam logic [9:0] IDX_B_TIM_IN_B = 10'h31B;
    localparam logic [9:0] IDX_A_OFS_P0_IN_A = 10'h344;
    localparam logic [9:0] IDX_A_OFS_P0_IN_B = 10'h346;
    localparam logic [9:0] IDX_A_OFS_P90_IN_A = 10'h348;

    // ----------------------------------------------------------------
    // Storage slots, one per register
    // ----------------------------------------------------------------
    localparam int NUM_REGS = 6;
    localparam logic [2:0] SEL_B_TIM_IN_A = 3'h0;
    localparam logic [2:0] SEL_A_TIM_IN_B = 3'h1;
    localparam logic [2:0] SEL_B_TIM_IN_B = 3'h2;
    localparam logic [2:0] SEL_A_OFS_P0_IN_A = 3'h3;
    localparam logic [2:0] SEL_A_OFS_P0_IN_B = 3'h4;
    localparam logic [2:0] SEL_A_OFS_P90_IN_A = 3'h5;
    localparam logic [2:0] SEL_NONE = 3'h7;

    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int TIM_W = 8;
    localparam int OFS_W = 12;
    localparam int REG_W = 16;
    localparam logic [15:0] MASK_TIM = 16'h00FF;
    localparam logic [15:0] MASK_OFS = 16'hFFFF;
    localparam logic [15:0] RESET_VAL = 16'h0000;
    localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Fuse load sequencer states, Gray along the path
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_WAIT = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN = 2'b11
    } actr_state_e;

    // Writable bits of each slot; timing slots keep only eight bits
    function automatic logic [15:0] entry_mask(input logic [2:0] sel);
        entry_mask = (sel <= SEL_B_TIM_IN_B) ? MASK_TIM : MASK_OFS;
    endfunction

endpackage

// ---- src/actr_top.sv ----
// AHB-Lite trim register bank for the timing trims of both cores and the offset trims of core A
//
// Notes on behaviour
// RULE_01 - Core B timing trim, interleaved, foreground cal, first input pair, fuse default.
// RULE_02 - Core A timing trim, interleaved, foreground cal, second input pair.
// RULE_03 - Core B timing trim, interleaved, foreground cal, second input pair.
// RULE_04 - Timing trim is one 8-bit read/write field covering the whole register.
// RULE_05 - Core A offset, 12 low bits of 16, phase 0, first input pair.
// RULE_06 - Core A offset, phase 0, second input pair, foreground cal enabled.
// RULE_07 - Core A offset, phase 90, first input pair, foreground cal enabled.
// RULE_08 - Offset registers 16 bits; top four reserved read/write; defaults from fuses.
// RULE_09 - Timing trims shift each core's sampling instant; one register per mode.
// RULE_10 - Fuse values are readable by software and may be overwritten.
// RULE_11 - Each value reaches its core only in its condition; stored value stays.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
module actr_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Factory fuse storage
    input wire logic fuse_ready,
    input wire logic [7:0] fuse_b_tim_in_a,
    input wire logic [7:0] fuse_a_tim_in_b,
    input wire logic [7:0] fuse_b_tim_in_b,
    input wire logic [15:0] fuse_a_ofs_p0_in_a,
    input wire logic [15:0] fuse_a_ofs_p0_in_b,
    input wire logic [15:0] fuse_a_ofs_p90_in_a,
    // Operating condition
    input wire logic interleaved_mode,
    input wire logic fg_cal_en,
    input wire logic clk_phase90,
    input wire logic second_input_pair_sel,
    // Trim values applied to the cores
    output logic [7:0] core_a_timing_trim,
    output logic core_a_timing_valid,
    output logic [7:0] core_b_timing_trim,
    output logic core_b_timing_valid,
    output logic [11:0] core_a_offset_trim,
    output logic core_a_offset_valid
);

    // ----------------------------------------------------------------
    // Fuse load sequencing
    // ----------------------------------------------------------------
    logic load_en;
    logic bank_ready;

    actr_fuse_loader u_loader (
        .mclk(mclk),
        .rst(rst),
        .fuse_ready(fuse_ready),
        .load_en(load_en),
        .bank_ready(bank_ready)
    );

    // Bus stalls until the fuse copy is in place, so software never reads zeros
    assign hreadyout = bank_ready;
    assign hresp = 1'b0;

    // ----------------------------------------------------------------
    // Address phase decode
    // ----------------------------------------------------------------
    logic addr_accept;
    logic [2:0] addr_sel;

    // Indices need ten bits; any higher address bit set means unmapped
    always_comb begin
        addr_accept = hsel && htrans[1] && hready;
        if (haddr[31:12] != 20'h00000 || haddr[1:0] != 2'b00) begin
            addr_sel = actr_pkg::SEL_NONE;
        end else if (haddr[11:2] == actr_pkg::IDX_B_TIM_IN_A) begin
            addr_sel = actr_pkg::SEL_B_TIM_IN_A;
        end else if (haddr[11:2] == actr_pkg::IDX_A_TIM_IN_B) begin
            addr_sel = actr_pkg::SEL_A_TIM_IN_B;
        end else if (haddr[11:2] == actr_pkg::IDX_B_TIM_IN_B) begin
            addr_sel = actr_pkg::SEL_B_TIM_IN_B;
        end else if (haddr[11:2] == actr_pkg::IDX_A_OFS_P0_IN_A) begin
            addr_sel = actr_pkg::SEL_A_OFS_P0_IN_A;
        end else if (haddr[11:2] == actr_pkg::IDX_A_OFS_P0_IN_B) begin
            addr_sel = actr_pkg::SEL_A_OFS_P0_IN_B;
        end else if (haddr[11:2] == actr_pkg::IDX_A_OFS_P90_IN_A) begin
            addr_sel = actr_pkg::SEL_A_OFS_P90_IN_A;
        end else begin
            addr_sel = actr_pkg::SEL_NONE;
        end
    end

    // ----------------------------------------------------------------
    // Data phase tracking
    // ----------------------------------------------------------------
    logic dp_write_q;
    logic dp_write_d;
    logic [2:0] dp_sel_q;
    logic [2:0] dp_sel_d;
    logic commit;

    // Remember an accepted write for its data phase
    always_comb begin
        dp_write_d = dp_write_q;
        dp_sel_d = dp_sel_q;
        if (hready) begin
            dp_write_d = addr_accept && hwrite && (addr_sel != actr_pkg::SEL_NONE);
            dp_sel_d = addr_sel;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            dp_write_q <= 1'b0;
            dp_sel_q <= actr_pkg::SEL_NONE;
        end else begin
            dp_write_q <= dp_write_d;
            dp_sel_q <= dp_sel_d;
        end
    end

    assign commit = dp_write_q && hreadyout;

    // ----------------------------------------------------------------
    // Trim storage
    // ----------------------------------------------------------------
    logic [15:0] regs_q [actr_pkg::NUM_REGS];
    logic [15:0] regs_d [actr_pkg::NUM_REGS];
    logic [15:0] fuse_val [actr_pkg::NUM_REGS];

    // Fuse images widened to the slot width; timing slots keep eight bits
    assign fuse_val[actr_pkg::SEL_B_TIM_IN_A] = {8'h00, fuse_b_tim_in_a};
    assign fuse_val[actr_pkg::SEL_A_TIM_IN_B] = {8'h00, fuse_a_tim_in_b};
    assign fuse_val[actr_pkg::SEL_B_TIM_IN_B] = {8'h00, fuse_b_tim_in_b};
    assign fuse_val[actr_pkg::SEL_A_OFS_P0_IN_A] = fuse_a_ofs_p0_in_a;
    assign fuse_val[actr_pkg::SEL_A_OFS_P0_IN_B] = fuse_a_ofs_p0_in_b;
    assign fuse_val[actr_pkg::SEL_A_OFS_P90_IN_A] = fuse_a_ofs_p90_in_a;

    // Fuse copy once after reset, then only software writes change a slot
    always_comb begin
        for (int i = 0; i < actr_pkg::NUM_REGS; i++) begin
            regs_d[i] = regs_q[i]; // [RULE_11]
            if (load_en) begin
                regs_d[i] = fuse_val[i] & actr_pkg::entry_mask(3'(i)); // [RULE_01] [RULE_08]
            end else if (commit && dp_sel_q == 3'(i)) begin
                // Timing slots drop bits above seven; offsets keep all sixteen
                regs_d[i] = hwdata[15:0] & actr_pkg::entry_mask(3'(i)); // [RULE_04] [RULE_10]
            end
        end
    end

    always_ff @(posedge mclk) begin
        for (int i = 0; i < actr_pkg::NUM_REGS; i++) begin
            if (rst) begin
                regs_q[i] <= actr_pkg::RESET_VAL;
            end else begin
                regs_q[i] <= regs_d[i]; // [RULE_02] [RULE_03] [RULE_05] [RULE_06] [RULE_07]
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Read value is captured in the address phase, so reads need no wait state;
    // a write still in its data phase to the same slot is forwarded
    always_comb begin
        rdata_d = actr_pkg::RDATA_IDLE;
        if (addr_accept && !hwrite && addr_sel != actr_pkg::SEL_NONE) begin
            if (commit && dp_sel_q == addr_sel) begin
                rdata_d = {16'h0000, hwdata[15:0] & actr_pkg::entry_mask(addr_sel)};
            end else begin
                rdata_d = {16'h0000, regs_q[addr_sel]}; // [RULE_10]
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= actr_pkg::RDATA_IDLE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign hrdata = rdata_q;

    // ----------------------------------------------------------------
    // Routing to the cores
    // ----------------------------------------------------------------
    actr_trim_route u_route (
        .mclk(mclk),
        .rst(rst),
        .interleaved_mode(interleaved_mode),
        .fg_cal_en(fg_cal_en),
        .clk_phase90(clk_phase90),
        .second_input_pair_sel(second_input_pair_sel),
        .tim_b_in_a(regs_q[actr_pkg::SEL_B_TIM_IN_A]),
        .tim_a_in_b(regs_q[actr_pkg::SEL_A_TIM_IN_B]),
        .tim_b_in_b(regs_q[actr_pkg::SEL_B_TIM_IN_B]),
        .ofs_a_p0_in_a(regs_q[actr_pkg::SEL_A_OFS_P0_IN_A]),
        .ofs_a_p0_in_b(regs_q[actr_pkg::SEL_A_OFS_P0_IN_B]),
        .ofs_a_p90_in_a(regs_q[actr_pkg::SEL_A_OFS_P90_IN_A]),
        .core_a_timing_trim(core_a_timing_trim), // [RULE_09]
        .core_a_timing_valid(core_a_timing_valid),
        .core_b_timing_trim(core_b_timing_trim),
        .core_b_timing_valid(core_b_timing_valid),
        .core_a_offset_trim(core_a_offset_trim),
        .core_a_offset_valid(core_a_offset_valid)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic wr_b_in_a;
    logic wr_a_in_b;
    logic wr_b_in_b;
    assign wr_b_in_a = commit && !load_en && dp_sel_q == actr_pkg::SEL_B_TIM_IN_A;
    assign wr_a_in_b = commit && !load_en && dp_sel_q == actr_pkg::SEL_A_TIM_IN_B;
    assign wr_b_in_b = commit && !load_en && dp_sel_q == actr_pkg::SEL_B_TIM_IN_B;

    b_first_wr_a: assert property (wr_b_in_a |=> // [RULE_01]
        regs_q[actr_pkg::SEL_B_TIM_IN_A] == {8'h00, $past(hwdata[7:0])})
        else $error("core B first pair timing write lost");

    a_second_wr_a: assert property (wr_a_in_b |=> // [RULE_02]
        regs_q[actr_pkg::SEL_A_TIM_IN_B] == {8'h00, $past(hwdata[7:0])})
        else $error("core A second pair timing write lost");

    tim_b_route_a: assert property ( // [RULE_03]
        (wr_b_in_b && interleaved_mode && fg_cal_en && second_input_pair_sel) ##1
        (interleaved_mode && fg_cal_en && second_input_pair_sel)
        |=> core_b_timing_trim == $past(hwdata[7:0], 2) && core_b_timing_valid)
        else $error("core B second pair timing not applied");

    tim_upper_zero_a: assert property ( // [RULE_04]
        (addr_accept && !hwrite && addr_sel <= actr_pkg::SEL_B_TIM_IN_B)
        |=> hrdata[31:8] == 24'h000000)
        else $error("timing register upper bits not zero");

    ofs_p0_first_a: assert property ( // [RULE_05]
        (fg_cal_en && !clk_phase90
         && !second_input_pair_sel)
        |=> core_a_offset_valid && core_a_offset_trim
            == $past(regs_q[actr_pkg::SEL_A_OFS_P0_IN_A][11:0]))
        else $error("phase 0 first pair offset not applied");

    ofs_p0_second_a: assert property ( // [RULE_06]
        (fg_cal_en && !clk_phase90 && second_input_pair_sel)
        |=> core_a_offset_trim == $past(regs_q[actr_pkg::SEL_A_OFS_P0_IN_B][11:0]))
        else $error("phase 0 second pair offset not applied");

    ofs_p90_first_a: assert property ( // [RULE_07]
        (fg_cal_en && clk_phase90 && !second_input_pair_sel)
        |=> core_a_offset_trim == $past(regs_q[actr_pkg::SEL_A_OFS_P90_IN_A][11:0]))
        else $error("phase 90 first pair offset not applied");

    fuse_load_a: assert property (load_en |=> // [RULE_08]
        regs_q[actr_pkg::SEL_A_OFS_P0_IN_A] == $past(fuse_a_ofs_p0_in_a)
        && regs_q[actr_pkg::SEL_B_TIM_IN_A] == {8'h00, $past(fuse_b_tim_in_a)})
        else $error("fuse values not copied");

    tim_gate_a: assert property (!(interleaved_mode && fg_cal_en) // [RULE_09]
        |=> !core_a_timing_valid && !core_b_timing_valid && core_b_timing_trim == 8'h00)
        else $error("timing trim applied outside its mode");

    readback_a: assert property ( // [RULE_10]
        (addr_accept && !hwrite && addr_sel == actr_pkg::SEL_A_OFS_P90_IN_A && !commit)
        |=> hrdata == {16'h0000, $past(regs_q[actr_pkg::SEL_A_OFS_P90_IN_A])})
        else $error("readback differs from stored value");

    hold_value_a: assert property ((!commit && !load_en) |=> // [RULE_11]
        $stable(regs_q[actr_pkg::SEL_A_OFS_P0_IN_B]) && $stable(regs_q[actr_pkg::SEL_B_TIM_IN_B]))
        else $error("stored trim changed without a write");

    a_tim_route_a: assert property ( // [RULE_02]
        (interleaved_mode && fg_cal_en && second_input_pair_sel)
        |=> core_a_timing_valid
        && core_a_timing_trim == $past(regs_q[actr_pkg::SEL_A_TIM_IN_B][7:0]))
        else $error("core A timing not applied");

    unmapped_wr_a: assert property ( // [RULE_11]
        (addr_accept && hwrite && addr_sel == actr_pkg::SEL_NONE)
        |=> !dp_write_q)
        else $error("unmapped write accepted");

    ofs_gate_a: assert property (!fg_cal_en |=> // [RULE_11]
        !core_a_offset_valid && core_a_offset_trim == 12'h000)
        else $error("offset applied without calibration");

    write_read_c: cover property (wr_b_in_b ##1 (addr_accept && !hwrite));
    fuse_load_c: cover property (load_en ##1 bank_ready);
    phase90_c: cover property (core_a_offset_valid && clk_phase90 ##1 core_a_offset_valid);
    unmapped_c: cover property (addr_accept && addr_sel == actr_pkg::SEL_NONE);

endmodule

// ---- src/actr_trim_route.sv ----
// Steers each stored trim value to its core for the active operating condition
`timescale 1ns/1ps
module actr_trim_route (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Operating condition
    input wire logic interleaved_mode,
    input wire logic fg_cal_en,
    input wire logic clk_phase90,
    input wire logic second_input_pair_sel,
    // Stored values
    input wire logic [15:0] tim_b_in_a,
    input wire logic [15:0] tim_a_in_b,
    input wire logic [15:0] tim_b_in_b,
    input wire logic [15:0] ofs_a_p0_in_a,
    input wire logic [15:0] ofs_a_p0_in_b,
    input wire logic [15:0] ofs_a_p90_in_a,
    // Values applied to the cores
    output logic [7:0] core_a_timing_trim,
    output logic core_a_timing_valid,
    output logic [7:0] core_b_timing_trim,
    output logic core_b_timing_valid,
    output logic [11:0] core_a_offset_trim,
    output logic core_a_offset_valid
);

    logic [7:0] a_tim_d;
    logic [7:0] b_tim_d;
    logic [11:0] a_ofs_d;
    logic a_tim_v_d;
    logic b_tim_v_d;
    logic a_ofs_v_d;
    logic fg_il;

    // Select per condition; nothing applies outside the documented cases
    always_comb begin
        fg_il = interleaved_mode && fg_cal_en;
        a_tim_v_d = fg_il && second_input_pair_sel;
        a_tim_d = a_tim_v_d ? tim_a_in_b[7:0] : 8'h00;
        b_tim_v_d = fg_il;
        b_tim_d = !fg_il ? 8'h00 : (second_input_pair_sel ? tim_b_in_b[7:0] : tim_b_in_a[7:0]);
        a_ofs_v_d = 1'b0;
        a_ofs_d = 12'h000;
        if (fg_cal_en && !clk_phase90 && !second_input_pair_sel) begin
            a_ofs_v_d = 1'b1;
            a_ofs_d = ofs_a_p0_in_a[11:0];
        end else if (fg_cal_en && !clk_phase90) begin
            a_ofs_v_d = 1'b1;
            a_ofs_d = ofs_a_p0_in_b[11:0];
        end else if (fg_cal_en && !second_input_pair_sel) begin
            a_ofs_v_d = 1'b1;
            a_ofs_d = ofs_a_p90_in_a[11:0];
        end
    end

    // Registered so the analog side sees glitch-free values
    always_ff @(posedge mclk) begin
        if (rst) begin
            core_a_timing_trim <= 8'h00;
            core_b_timing_trim <= 8'h00;
            core_a_offset_trim <= 12'h000;
            core_a_timing_valid <= 1'b0;
            core_b_timing_valid <= 1'b0;
            core_a_offset_valid <= 1'b0;
        end else begin
            core_a_timing_trim <= a_tim_d;
            core_b_timing_trim <= b_tim_d;
            core_a_offset_trim <= a_ofs_d;
            core_a_timing_valid <= a_tim_v_d;
            core_b_timing_valid <= b_tim_v_d;
            core_a_offset_valid <= a_ofs_v_d;
        end
    end

endmodule
